// >>> core/btq_pkg.sv
`default_nettype none
package btq_pkg;
   // ************
   // trace record
   // ************
   localparam int REC_W = 70;
   localparam int ADDR_LSB = 46;
   localparam int DATA_LSB = 30;
   localparam int STAT_LSB = 16;
   localparam int PROBE_LSB = 0;
   localparam int STAT_W = 14;
   localparam int AUX_W = 5;
   localparam int TIMER_W = 24;
   localparam int PIN_W = 133;
   // ************
   // trace modes
   // ************
   localparam logic [1:0] MODE_NARROW = 2'h0;
   localparam logic [1:0] MODE_WIDE_DATA = 2'h1;
   localparam logic [1:0] MODE_WIDE_ALL = 2'h2;
   localparam logic [1:0] MODE_FULL_STAT = 2'h3;
   // ************
   // event groups and actions
   // ************
   localparam int NUM_GROUPS = 4;
   localparam int NUM_ACT = 6;
   localparam int ACT_BRK = 0;
   localparam int ACT_TRC = 1;
   localparam int ACT_TOT = 2;
   localparam int ACT_CNT = 3;
   localparam int ACT_RCT = 4;
   localparam int ACT_GRO = 5;
   localparam logic [1:0] GROUP_FIRST = 2'h0;
   localparam int LIMIT_W = 16;
   localparam logic [LIMIT_W-1:0] LIMIT_RESET = 16'h0000;
   localparam logic [TIMER_W-1:0] TIMER_RESET = 24'h000000;
   // ************
   // commands
   // ************
   typedef enum logic [2:0] {
      CMD_RUN = 3'b000,
      CMD_RUN_WITH_BREAKS = 3'b001,
      CMD_RUN_BREAKS_LOAD_VECTORS = 3'b010,
      CMD_RUN_NOBREAK_LOAD_VECTORS = 3'b011,
      CMD_STOP = 3'b100
   } btq_cmd_e;
endpackage
`default_nettype wire

// >>> core/btq_record_mux.sv
`default_nettype none
module btq_record_mux
   import btq_pkg::*;
(
   input wire logic [1:0] mode,
   input wire logic [31:0] addr,
   input wire logic [31:0] data,
   input wire logic [2:0] functionCode,
   input wire logic readWrite,
   input wire logic targetOverlaySelect,
   input wire logic byteWord,
   input wire logic interruptPendingOut,
   input wire logic autovectorRequest,
   input wire logic [2:0] interruptLevel,
   input wire logic busErrorFlag,
   input wire logic accessViolationFlag,
   input wire logic operandStart,
   input wire logic transferAckHi,
   input wire logic transferAckLo,
   input wire logic transferSizeHi,
   input wire logic transferSizeLo,
   input wire logic readModifyWriteFlag,
   input wire logic cacheDisableIn,
   input wire logic [15:0] probeLines,
   input wire logic breakFlag,
   output logic [REC_W-1:0] record,
   output logic [AUX_W-1:0] aux
);
   logic [STAT_W-1:0] status;
   logic [15:0] probeField;

   // ************
   // status field, S15 and S3 are constant zero and not stored
   // ************
   always_comb
   begin
      if (mode == MODE_WIDE_ALL)
      begin
         status = {addr[31:24], functionCode, targetOverlaySelect,
            readWrite, byteWord};
      end
      else
      begin
         status = {interruptPendingOut, autovectorRequest, breakFlag,
            interruptLevel, busErrorFlag, accessViolationFlag,
            functionCode, targetOverlaySelect, readWrite,
            byteWord};
      end
   end

   // ************
   // probe field
   // ************
   always_comb
   begin
      if (mode == MODE_NARROW)
      begin
         probeField = probeLines;
      end
      else if (mode == MODE_FULL_STAT)
      begin
         probeField = {addr[31:24], readModifyWriteFlag, cacheDisableIn,
            probeLines[5:0]};
      end
      else
      begin
         probeField = data[15:0];
      end
   end

   // address low 24 and data high 16 are kept in every mode
   assign record = {addr[23:0], data[31:16], status, probeField};
   assign aux = {operandStart, transferAckHi, transferAckLo,
      transferSizeHi, transferSizeLo};
endmodule
`default_nettype wire

// >>> core/btq_top.sv
`default_nettype none
module btq_top
   import btq_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic busCycleDone,
   input wire logic [31:0] busAddr,
   input wire logic [31:0] busData,
   input wire logic [31:0] programCounter,
   input wire logic [2:0] functionCode,
   input wire logic readWrite,
   input wire logic targetOverlaySelect,
   input wire logic byteWord,
   input wire logic interruptPendingOut,
   input wire logic autovectorRequest,
   input wire logic [2:0] interruptLevel,
   input wire logic busErrorFlag,
   input wire logic accessViolationFlag,
   input wire logic operandStart,
   input wire logic transferAckHi,
   input wire logic transferAckLo,
   input wire logic transferSizeHi,
   input wire logic transferSizeLo,
   input wire logic readModifyWriteFlag,
   input wire logic cacheDisableIn,
   input wire logic [15:0] probeLines,
   input wire logic [1:0] traceMode,
   input wire logic cmdValid,
   input wire logic [2:0] cmdCode,
   input wire logic resetCharSeen,
   input wire logic stmtWrite,
   input wire logic [1:0] stmtGroup,
   input wire logic [NUM_ACT-1:0] stmtActions,
   input wire logic clearEventStatements,
   input wire logic clearAllGroups,
   input wire logic [1:0] clearGroup,
   input wire logic limitWrite,
   input wire logic [1:0] limitGroup,
   input wire logic [LIMIT_W-1:0] limitValue,
   input wire logic [NUM_ACT-1:0] eventHit,
   input wire logic [1:0] groupTarget,
   output logic emulating,
   output logic breaksEnabled,
   output logic cmdRefused,
   output logic loadVectors,
   output logic breakFired,
   output logic [31:0] reportPc,
   output logic [1:0] reportGroup,
   output logic [1:0] activeGroup,
   output logic sampleValid,
   output logic [REC_W-1:0] traceRecord,
   output logic [AUX_W-1:0] traceAux,
   output logic [TIMER_W-1:0] traceTime,
   output logic traceWrite,
   output logic tracingOn,
   output logic [LIMIT_W-1:0] eventCounter
);
   // ************
   // reset release and pin synchronisers
   // ************
   logic [1:0] rstPipe_reg;
   logic rstSyncN;
   logic [PIN_W-1:0] pinRaw;
   logic [PIN_W-1:0] pinMeta_reg;
   logic [PIN_W-1:0] pinSync_reg;
   logic doneLast_reg;
   logic sDone, sRw, sTgt, sBw, sIp, sAv, sBer, sMav;
   logic sOcs, sAckHi, sAckLo, sSizHi, sSizLo, sRmw, sCdis;
   logic [31:0] sAddr, sData, sPc;
   logic [2:0] sFc, sIpl;
   logic [15:0] sProbe;
   logic cycleEdge;

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         rstPipe_reg <= 2'h0;
      else
         rstPipe_reg <= {rstPipe_reg[0], 1'b1};
   end
   assign rstSyncN = rstPipe_reg[1];

   assign pinRaw = {busCycleDone, busAddr, busData, programCounter,
      functionCode, readWrite, targetOverlaySelect, byteWord,
      interruptPendingOut, autovectorRequest, interruptLevel,
      busErrorFlag, accessViolationFlag, operandStart, transferAckHi,
      transferAckLo, transferSizeHi, transferSizeLo, readModifyWriteFlag,
      cacheDisableIn, probeLines};

   // pins are held stable around the completion edge, so each bit
   // settles together after two stages
   always_ff @(posedge ref_clk or negedge rstSyncN)
   begin
      if (!rstSyncN)
      begin
         pinMeta_reg <= '0;
         pinSync_reg <= '0;
         doneLast_reg <= 1'b0;
      end
      else
      begin
         pinMeta_reg <= pinRaw;
         pinSync_reg <= pinMeta_reg;
         doneLast_reg <= sDone;
      end
   end

   assign {sDone, sAddr, sData, sPc, sFc, sRw, sTgt, sBw, sIp, sAv, sIpl,
      sBer, sMav, sOcs, sAckHi, sAckLo, sSizHi, sSizLo, sRmw, sCdis,
      sProbe} = pinSync_reg;
   assign cycleEdge = sDone && !doneLast_reg;

   // ************
   // snapshot of each completed bus cycle
   // ************
   logic [REC_W-1:0] recordNext;
   logic [AUX_W-1:0] auxNext;
   logic [TIMER_W-1:0] timer_reg;
   logic [31:0] pcSnap_reg;
   logic sampleValid_reg;

   btq_record_mux btq_record_mux_i (
      .mode(traceMode),
      .addr(sAddr),
      .data(sData),
      .functionCode(sFc),
      .readWrite(sRw),
      .targetOverlaySelect(sTgt),
      .byteWord(sBw),
      .interruptPendingOut(sIp),
      .autovectorRequest(sAv),
      .interruptLevel(sIpl),
      .busErrorFlag(sBer),
      .accessViolationFlag(sMav),
      .operandStart(sOcs),
      .transferAckHi(sAckHi),
      .transferAckLo(sAckLo),
      .transferSizeHi(sSizHi),
      .transferSizeLo(sSizLo),
      .readModifyWriteFlag(sRmw),
      .cacheDisableIn(sCdis),
      .probeLines(sProbe),
      .breakFlag(breakFired),
      .record(recordNext),
      .aux(auxNext)
   );

   always_ff @(posedge ref_clk or negedge rstSyncN)
   begin
      if (!rstSyncN)
         timer_reg <= TIMER_RESET;
      else
         timer_reg <= timer_reg + 24'h000001;
   end

   // comparators outside read traceRecord, so both see one snapshot
   always_ff @(posedge ref_clk or negedge rstSyncN)
   begin
      if (!rstSyncN)
      begin
         traceRecord <= '0;
         traceAux <= '0;
         traceTime <= TIMER_RESET;
         pcSnap_reg <= 32'h00000000;
         sampleValid_reg <= 1'b0;
      end
      else
      begin
         sampleValid_reg <= cycleEdge;
         if (cycleEdge)
         begin
            traceRecord <= recordNext;
            traceAux <= auxNext;
            traceTime <= timer_reg;
            pcSnap_reg <= sPc;
         end
      end
   end
   assign sampleValid = sampleValid_reg;

   // ************
   // statements and count limits per group
   // ************
   logic [NUM_ACT-1:0] actDefined_reg [NUM_GROUPS];
   logic [LIMIT_W-1:0] limit_reg [NUM_GROUPS];

   for (genvar g = 0; g < NUM_GROUPS; g++)
   begin : groupStore
      always_ff @(posedge ref_clk or negedge rstSyncN)
      begin
         if (!rstSyncN)
            actDefined_reg[g] <= '0;
         else if (clearEventStatements &&
            (clearAllGroups || clearGroup == 2'(g)))
            actDefined_reg[g] <= '0;
         else if (stmtWrite && stmtGroup == 2'(g))
            actDefined_reg[g] <= actDefined_reg[g] | stmtActions;
      end
      // comparator values ignore the clear command entirely
      always_ff @(posedge ref_clk or negedge rstSyncN)
      begin
         if (!rstSyncN)
            limit_reg[g] <= LIMIT_RESET;
         else if (limitWrite && limitGroup == 2'(g))
            limit_reg[g] <= limitValue;
      end
   end

   // ************
   // run control
   // ************
   logic isRun, isRunBrk, isVecBrk, isVecNoBrk, isStop;
   logic enterEmu, evalCycle;
   logic [NUM_ACT-1:0] fire;

   assign isRun = cmdValid && cmdCode == CMD_RUN;
   assign isRunBrk = cmdValid && cmdCode == CMD_RUN_WITH_BREAKS;
   assign isVecBrk = cmdValid && cmdCode == CMD_RUN_BREAKS_LOAD_VECTORS;
   assign isVecNoBrk = cmdValid && cmdCode == CMD_RUN_NOBREAK_LOAD_VECTORS;
   assign isStop = cmdValid && cmdCode == CMD_STOP;
   assign enterEmu = !emulating && (isRun || isRunBrk || isVecBrk ||
      isVecNoBrk);
   assign evalCycle = emulating && sampleValid_reg;
   assign fire = evalCycle ? (eventHit & actDefined_reg[activeGroup]) : '0;

   always_ff @(posedge ref_clk or negedge rstSyncN)
   begin
      if (!rstSyncN)
      begin
         emulating <= 1'b0;
         breaksEnabled <= 1'b0;
      end
      else if (enterEmu)
      begin
         emulating <= 1'b1;
         breaksEnabled <= isRunBrk || isVecBrk;
      end
      else if (emulating)
      begin
         if (isStop || resetCharSeen)
            emulating <= 1'b0;
         else if (fire[ACT_BRK] && breaksEnabled)
            emulating <= 1'b0;
         if (isRunBrk)
            breaksEnabled <= 1'b1;
         else if (isRun)
            breaksEnabled <= 1'b0;
      end
   end

   // a refused command leaves emulation untouched
   always_ff @(posedge ref_clk or negedge rstSyncN)
   begin
      if (!rstSyncN)
      begin
         cmdRefused <= 1'b0;
         loadVectors <= 1'b0;
      end
      else
      begin
         cmdRefused <= emulating && (isVecBrk || isVecNoBrk);
         loadVectors <= !emulating && (isVecBrk || isVecNoBrk);
      end
   end

   always_ff @(posedge ref_clk or negedge rstSyncN)
   begin
      if (!rstSyncN)
      begin
         breakFired <= 1'b0;
         reportPc <= 32'h00000000;
         reportGroup <= GROUP_FIRST;
      end
      else
      begin
         breakFired <= emulating && !isStop && !resetCharSeen &&
            fire[ACT_BRK] && breaksEnabled;
         if (emulating && fire[ACT_BRK] && breaksEnabled)
         begin
            reportPc <= pcSnap_reg;
            reportGroup <= activeGroup;
         end
      end
   end

   // ************
   // event group and counter
   // ************
   always_ff @(posedge ref_clk or negedge rstSyncN)
   begin
      if (!rstSyncN)
         activeGroup <= GROUP_FIRST;
      else if (enterEmu)
         activeGroup <= GROUP_FIRST;
      else if (fire[ACT_GRO])
         activeGroup <= groupTarget;
   end

   // reload wins over a count on the same cycle
   always_ff @(posedge ref_clk or negedge rstSyncN)
   begin
      if (!rstSyncN)
         eventCounter <= LIMIT_RESET;
      else if (enterEmu)
         eventCounter <= limit_reg[GROUP_FIRST];
      else if (fire[ACT_RCT])
         eventCounter <= limit_reg[activeGroup];
      else if (fire[ACT_CNT])
         eventCounter <= eventCounter - 16'h0001;
   end

   // ************
   // trace qualification
   // ************
   logic defTrc, defTot, toggleOn;

   assign defTrc = actDefined_reg[activeGroup][ACT_TRC];
   assign defTot = actDefined_reg[activeGroup][ACT_TOT];
   assign toggleOn = tracingOn ^ fire[ACT_TOT];

   // toggle starts off on entry and on each group change, so the new
   // group alone decides what is traced next
   always_ff @(posedge ref_clk or negedge rstSyncN)
   begin
      if (!rstSyncN)
         tracingOn <= 1'b0;
      else if (enterEmu || fire[ACT_GRO])
         tracingOn <= 1'b0;
      else if (fire[ACT_TOT])
         tracingOn <= !tracingOn;
   end

   // the cycle that turns tracing on is itself recorded
   always_comb
   begin
      if (!evalCycle)
         traceWrite = 1'b0;
      else if (!defTrc && !defTot)
         traceWrite = 1'b1;
      else
         traceWrite = (defTrc && fire[ACT_TRC]) ||
            (defTot && toggleOn);
   end

   // ************
   // assertions
   // ************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstSyncN);

   refuse_vectors_a: assert property (
      emulating && (isVecBrk || isVecNoBrk) |=> cmdRefused && emulating &&
         !loadVectors)
      else $error("vector run not refused during emulation");

   entry_group_a: assert property (
      enterEmu |=> activeGroup == GROUP_FIRST && emulating && !tracingOn)
      else $error("emulation entry not at first group");

   break_halt_a: assert property (
      breakFired |-> !emulating && reportGroup == $past(activeGroup) &&
         reportPc == $past(pcSnap_reg))
      else $error("break did not halt and report");

   break_gate_a: assert property (
      emulating && !breaksEnabled && !isRunBrk && !isStop &&
         !resetCharSeen |=> emulating && !breakFired)
      else $error("break taken with breaks disabled");

   break_switch_a: assert property (
      emulating && !isStop && !resetCharSeen && (isRun || isRunBrk) |=>
         breaksEnabled == $past(isRunBrk) &&
         emulating == !$past(fire[ACT_BRK] && breaksEnabled))
      else $error("run command did not switch breaks");

   stop_halt_a: assert property (
      emulating && (isStop || resetCharSeen) |=> !emulating)
      else $error("stop did not halt emulation");

   clear_keeps_a: assert property (
      clearEventStatements && clearAllGroups && !limitWrite |=>
         actDefined_reg[0] == '0 && limit_reg[0] == $past(limit_reg[0]))
      else $error("clear touched comparator values");

   trace_all_a: assert property (
      evalCycle && actDefined_reg[activeGroup][ACT_TOT:ACT_TRC] == 2'h0
         |-> traceWrite)
      else $error("unqualified cycle not recorded");

   group_trace_a: assert property (
      fire[ACT_GRO] |=> !tracingOn)
      else $error("group change kept toggle state");

   toggle_flip_a: assert property (
      fire[ACT_TOT] && !fire[ACT_GRO] |=> tracingOn != $past(tracingOn))
      else $error("toggle did not invert tracing");

   count_step_a: assert property (
      fire[ACT_CNT] && !fire[ACT_RCT] && !enterEmu |=>
         eventCounter == $past(eventCounter) - 16'h0001)
      else $error("counter did not decrement");

   snapshot_a: assert property (
      cycleEdge |=> sampleValid && traceTime == $past(timer_reg) &&
         traceRecord == $past(recordNext))
      else $error("snapshot not taken at cycle completion");

   cover_break_c: cover property (breakFired);
   cover_toggle_c: cover property (fire[ACT_TOT] ##[1:50] fire[ACT_TOT]);
   cover_group_c: cover property (fire[ACT_GRO] ##1 activeGroup != 2'h0);
   cover_refuse_c: cover property (cmdRefused);
endmodule
`default_nettype wire

// >>> sim/btq_bus_model.sv
`default_nettype none
// ************
// target bus side: one completed cycle per call
// ************
module btq_bus_model
(
   input wire logic ref_clk,
   output logic cycleDone,
   output logic [31:0] addrPins,
   output logic [31:0] dataPins,
   output logic [31:0] pcPins,
   output logic [19:0] statPins,
   output logic [15:0] probePins
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      cycleDone = 1'b0;
      addrPins = 32'h0;
      dataPins = 32'h0;
      pcPins = 32'h0;
      statPins = 20'h0;
      probePins = 16'h0;
   end
   // slow adds wait states before completion; pins settle first
   task automatic busCycle(input logic [31:0] a, d, pc,
      input logic [19:0] st, input logic [15:0] pr, input int slow);
      @(negedge ref_clk);
      addrPins = a;
      dataPins = d;
      pcPins = pc;
      statPins = st;
      probePins = pr;
      repeat (2 + slow) @(negedge ref_clk);
      cycleDone = 1'b1;
      repeat (4) @(negedge ref_clk);
      cycleDone = 1'b0;
      repeat (2) @(negedge ref_clk);
      // released bus shows no stale value
      addrPins = ~a;
      dataPins = ~d;
      pcPins = ~pc;
      statPins = ~st;
      probePins = ~pr;
      @(negedge ref_clk);
   endtask
endmodule
`default_nettype wire

// >>> sim/bus_trace_qualifier_bench.sv
`default_nettype none
module bus_trace_qualifier_bench
   import btq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ************
   // stimulus and observation
   // ************
   logic ref_clk = 1'b0, rstn, busCycleDone, cmdValid, resetCharSeen;
   logic [31:0] busAddr, busData, programCounter, pcVal;
   logic [19:0] sp;
   logic [15:0] probeLines, limitValue, eventCounter;
   logic [1:0] traceMode, stmtGroup, clearGroup, limitGroup, groupTarget;
   logic [2:0] cmdCode;
   logic [5:0] stmtActions, eventHit;
   logic stmtWrite, clearEventStatements, clearAllGroups, limitWrite;
   logic emulating, breaksEnabled, cmdRefused, loadVectors, breakFired;
   logic [31:0] reportPc;
   logic [1:0] reportGroup, activeGroup;
   logic sampleValid, traceWrite, tracingOn, gotWr;
   logic [REC_W-1:0] traceRecord, gotRec;
   logic [AUX_W-1:0] traceAux, gotAux;
   logic [TIMER_W-1:0] traceTime, gotTime, lastTime, tick, gotTick, lastTick;
   int err_total = 0, checks_done = 0, nSamp = 0, nBrk = 0, slow = 0;
   always #25 ref_clk = ~ref_clk;
   btq_bus_model btq_bus_model_i (.ref_clk, .cycleDone(busCycleDone),
      .addrPins(busAddr), .dataPins(busData), .pcPins(programCounter),
      .statPins(sp), .probePins(probeLines));
   btq_top btq_top_i (.ref_clk, .rstn, .busCycleDone, .busAddr, .busData,
      .programCounter, .functionCode(sp[2:0]), .readWrite(sp[3]),
      .targetOverlaySelect(sp[4]), .byteWord(sp[5]),
      .interruptPendingOut(sp[6]), .autovectorRequest(sp[7]),
      .interruptLevel(sp[10:8]), .busErrorFlag(sp[11]),
      .accessViolationFlag(sp[12]), .operandStart(sp[13]),
      .transferAckHi(sp[14]), .transferAckLo(sp[15]),
      .transferSizeHi(sp[16]), .transferSizeLo(sp[17]),
      .readModifyWriteFlag(sp[18]), .cacheDisableIn(sp[19]), .probeLines,
      .traceMode, .cmdValid, .cmdCode, .resetCharSeen, .stmtWrite,
      .stmtGroup, .stmtActions, .clearEventStatements, .clearAllGroups,
      .clearGroup, .limitWrite, .limitGroup, .limitValue, .eventHit,
      .groupTarget, .emulating, .breaksEnabled, .cmdRefused, .loadVectors,
      .breakFired, .reportPc, .reportGroup, .activeGroup, .sampleValid,
      .traceRecord, .traceAux, .traceTime, .traceWrite, .tracingOn,
      .eventCounter);
   always @(posedge ref_clk) tick <= tick + 24'h1;
   always @(negedge ref_clk)
   begin
      if (sampleValid === 1'b1)
      begin
         nSamp++;
         gotRec = traceRecord;
         gotAux = traceAux;
         gotTime = traceTime;
         gotWr = traceWrite;
         gotTick = tick;
      end
      if (breakFired === 1'b1) nBrk++;
   end
   // ************
   // access tasks
   // ************
   task automatic chk(input logic [69:0] got, exp, input string what);
      checks_done++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED at %0t: %s got %h", $time, what, got);
      end
   endtask
   task automatic cmd(input logic [2:0] c);
      @(negedge ref_clk) {cmdValid, cmdCode} = {1'b1, c};
      @(negedge ref_clk) cmdValid = 1'b0;
   endtask
   task automatic stmt(input logic [1:0] g, input logic [5:0] a);
      @(negedge ref_clk) {stmtWrite, stmtGroup, stmtActions} = {1'b1, g, a};
      @(negedge ref_clk) stmtWrite = 1'b0;
   endtask
   task automatic clr(input logic all, input logic [1:0] g);
      @(negedge ref_clk) {clearEventStatements, clearAllGroups} = {1'b1, all};
      clearGroup = g;
      @(negedge ref_clk) clearEventStatements = 1'b0;
   endtask
   task automatic lim(input logic [1:0] g, input logic [15:0] v);
      @(negedge ref_clk) {limitWrite, limitGroup, limitValue} = {1'b1, g, v};
      @(negedge ref_clk) limitWrite = 1'b0;
   endtask
   task automatic cyc(input logic [31:0] a, d, input logic [5:0] h);
      int n0;
      n0 = nSamp;
      eventHit = h;
      slow = 2 - slow;
      btq_bus_model_i.busCycle(a, d, pcVal, 20'ha5c3b, 16'h3c96, slow);
      // hits stay put: they are read only while a snapshot is fresh
      chk(nSamp - n0, 1, "snapshots");
   endtask
   // break flag is zero on these cycles
   function automatic logic [69:0] expRec(logic [1:0] m,
      logic [31:0] a, d, logic [19:0] s, logic [15:0] p);
      logic [13:0] st;
      logic [15:0] pb;
      st = {s[6], s[7], 1'b0, s[10:8], s[11], s[12], s[2:0], s[4], s[3],
         s[5]};
      if (m == 2'h2) st[13:6] = a[31:24];
      pb = (m == 2'h0) ? p : (m == 2'h3) ?
         {a[31:24], s[18], s[19], p[5:0]} : d[15:0];
      return {a[23:0], d[31:16], st, pb};
   endfunction
   task automatic give_verdict;
      $display("mismatches %0d, comparisons %0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (5000) @(posedge ref_clk);
      err_total++;
      give_verdict;
   end
   // ************
   // tests
   // ************
   initial
   begin
      {rstn, cmdValid, cmdCode, resetCharSeen, stmtWrite} = '0;
      {stmtGroup, stmtActions, clearEventStatements, clearAllGroups} = '0;
      {clearGroup, limitWrite, limitGroup, limitValue, eventHit} = '0;
      {groupTarget, traceMode, pcVal, tick} = '0;
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk) rstn = 1'b1;
      repeat (3) @(negedge ref_clk);
      chk(emulating, 0, "reset");
      cmd(3'h3);
      chk(loadVectors, 1, "vec run");
      chk({emulating, breaksEnabled}, 2'b10, "run nobrk");
      for (int m = 0; m < 4; m++)
      begin
         traceMode = 2'(m);
         cyc(32'h9a12_3456 + m, 32'hc3d4_e5f6 - m, 6'h0);
         chk(gotRec, expRec(2'(m), 32'h9a12_3456 + m, 32'hc3d4_e5f6 - m,
            20'ha5c3b, 16'h3c96), "record");
         chk(gotAux, 5'b01001, "aux");
         chk(gotWr, 1, "trace all");
         if (m > 0) chk(gotTime - lastTime, gotTick - lastTick, "tm");
         lastTime = gotTime;
         lastTick = gotTick;
      end
      cmd(3'h1);
      chk({emulating, breaksEnabled}, 2'b11, "brk on");
      cmd(3'h2);
      chk({cmdRefused, emulating, breaksEnabled}, 3'b111, "refuse");
      cmd(3'h0);
      chk(breaksEnabled, 0, "brk off");
      stmt(2'h0, 6'h01);
      cyc(32'h10, 32'h0, 6'h01);
      chk({nBrk, emulating}, 1, "brk ignored");
      cmd(3'h1);
      pcVal = 32'h0004_2a10;
      cyc(32'h20, 32'h0, 6'h01);
      chk({nBrk, emulating}, 2, "brk halts");
      chk({reportPc, reportGroup}, {pcVal, 2'h0}, "brk report");
      cmd(3'h0);
      cmd(3'h4);
      chk(emulating, 0, "stop");
      cmd(3'h0);
      @(negedge ref_clk) resetCharSeen = 1'b1;
      @(negedge ref_clk) resetCharSeen = 1'b0;
      chk(emulating, 0, "reset char");
      clr(1'b1, 2'h0);
      lim(2'h0, 16'h0005);
      lim(2'h2, 16'h0009);
      stmt(2'h0, 6'b101000);
      stmt(2'h2, 6'b010100);
      cmd(3'h1);
      chk({activeGroup, eventCounter}, {2'h0, 16'h5}, "entry");
      cyc(32'h30, 32'h0, 6'h01);
      chk(emulating, 1, "cleared brk");
      groupTarget = 2'h2;
      cyc(32'h40, 32'h0, 6'b101000);
      chk({activeGroup, eventCounter}, {2'h2, 16'h4}, "grp cnt");
      cyc(32'h50, 32'h0, 6'h0);
      chk({gotWr, tracingOn}, 0, "tog off");
      cyc(32'h60, 32'h0, 6'b000100);
      chk({gotWr, tracingOn}, 2'b11, "tog on");
      cyc(32'h70, 32'h0, 6'h0);
      chk(gotWr, 1, "tog hold");
      cyc(32'h80, 32'h0, 6'b010100);
      chk({gotWr, tracingOn}, 0, "tog off");
      chk(eventCounter, 16'h9, "reload");
      cmd(3'h4);
      cmd(3'h0);
      chk({activeGroup, eventCounter}, {2'h0, 16'h5}, "reentry");
      stmt(2'h0, 6'b000010);
      cyc(32'h90, 32'h0, 6'h0);
      chk(gotWr, 0, "unqual");
      cyc(32'ha0, 32'h0, 6'b000010);
      chk(gotWr, 1, "qual");
      clr(1'b0, 2'h0);
      cyc(32'hb0, 32'h0, 6'h0);
      chk(gotWr, 1, "cleared");
      give_verdict;
   end
endmodule
`default_nettype wire
